// ---- inc/fog_pkg.sv ----
// Function
// - Both shared pins reset to fail-output use
// - Alternates: wake input, low-side, high-side switch
// - Wake input filtered like dedicated wake pins
// - Shared-pin wake events latched in wake status
// - GPIO level readable in Normal and Stop
// - Level readback also while driving as switch
// - Second pin level bit equals strap level in Normal and Stop
// - Pin settings change only in Normal mode
// - Stop/Sleep keep settings; wake pins stay capable
// - Fail outputs active in Fail-Safe, failure Restart
// - Wake pin: Restart capable, Fail-Safe off, resumes
// - Switches off during Restart and Fail-Safe
// - Switches resume after Restart, register untouched
// - Failure fail output stays into Normal mode
// - Pulse duty defaults 20 percent, software selectable
// - Strap input filtered nominal 64 microseconds
// - Switches raise no diagnostic flags
// - Indicator output toggles 1.25 Hz, 50 percent
// - Pulsed output runs PWM at 100 Hz
// - Duty choices 20, 10, 5, 2.5 percent
package fog_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 50;

    // Register byte offsets
    localparam logic [7:0] ADDR_PIN_CFG   = 8'h00;
    localparam logic [7:0] ADDR_SW_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_WAKE_STAT = 8'h08;
    localparam logic [7:0] ADDR_LVL_STAT  = 8'h0C;

    // Field positions
    localparam int CFG_W      = 3;
    localparam int CFG_A_LSB  = 0;
    localparam int CFG_B_LSB  = 4;
    localparam int DUTY_W     = 2;
    localparam int DUTY_LSB   = 8;

    // Pin function codes
    localparam logic [2:0] FUNC_FAIL  = 3'h0;
    localparam logic [2:0] FUNC_OFF   = 3'h1;
    localparam logic [2:0] FUNC_WAKE  = 3'h2;
    localparam logic [2:0] FUNC_LOW   = 3'h3;
    localparam logic [2:0] FUNC_HIGH  = 3'h4;

    // Duty select codes and their share in per mille
    localparam logic [1:0] DUTY_20    = 2'h0;
    localparam logic [1:0] DUTY_10    = 2'h1;
    localparam logic [1:0] DUTY_5     = 2'h2;
    localparam logic [1:0] DUTY_2P5   = 2'h3;
    localparam int PERMILLE_20  = 200;
    localparam int PERMILLE_10  = 100;
    localparam int PERMILLE_5   = 50;
    localparam int PERMILLE_2P5 = 25;

    // Reset values
    localparam logic [2:0]  CFG_RST      = FUNC_FAIL;
    localparam logic [1:0]  DUTY_RST     = DUTY_20;
    localparam logic [1:0]  SW_RST       = 2'h0;
    localparam logic [1:0]  WAKE_RST     = 2'h0;
    localparam logic [1:0]  LVL_RST      = 2'h3;
    localparam logic        FILT_LVL_RST = 1'b1;

    // Input filter, least time rounds up
    localparam int FILT_TIME_NS = 64000;
    localparam int FILT_CYC     = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Pattern time base
    localparam int TICK_NS      = 25000;
    localparam int TICK_CYC     = TICK_NS / CLK_PERIOD_NS;
    localparam int PWM_PERIOD_NS  = 10000000;
    localparam int PWM_TICKS_DEF  = PWM_PERIOD_NS / TICK_NS;
    localparam int BLINK_HALF_NS  = 400000000;
    localparam int BLINK_TICKS_DEF = BLINK_HALF_NS / TICK_NS;

    // AHB-Lite
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // System modes from the mode controller
    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } fog_mode_t;

    // Pulse high time in ticks for a duty code
    function automatic logic [15:0] fog_duty_ticks(input logic [1:0] sel,
                                                   input int period);
        int pm;
        pm = PERMILLE_20;
        case (sel)
            DUTY_10:  pm = PERMILLE_10;
            DUTY_5:   pm = PERMILLE_5;
            DUTY_2P5: pm = PERMILLE_2P5;
            default:  pm = PERMILLE_20;
        endcase
        return 16'((period * pm) / 1000);
    endfunction

endpackage

// ---- core/fog_pin_filt.sv ----
module fog_pin_filt (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Pin level from outside
    input  wire logic pin_raw,
    // Filtered level and change pulse
    output logic      level,
    output logic      change
);
    import fog_pkg::*;

    localparam logic [10:0] FILT_LAST = 11'(FILT_CYC - 1);

    logic        sync1_ff;
    logic        sync2_ff;
    logic        level_ff;
    logic        change_ff;
    logic [10:0] cnt_ff;
    logic        nxt_level;
    logic        nxt_change;
    logic [10:0] nxt_cnt;

    // New level taken only after it stood the whole filter time
    always_comb begin
        nxt_level  = level_ff;
        nxt_change = 1'b0;
        nxt_cnt    = 11'h000;
        if (sync2_ff != level_ff) begin
            if (cnt_ff == FILT_LAST) begin
                nxt_level  = sync2_ff;
                nxt_change = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 11'h001;
            end
        end
    end

    // Two-stage synchroniser; only the second stage feeds logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_ff  <= FILT_LVL_RST;
            sync2_ff  <= FILT_LVL_RST;
            level_ff  <= FILT_LVL_RST;
            change_ff <= 1'b0;
            cnt_ff    <= 11'h000;
        end else begin
            sync1_ff  <= pin_raw;
            sync2_ff  <= sync1_ff;
            level_ff  <= nxt_level;
            change_ff <= nxt_change;
            cnt_ff    <= nxt_cnt;
        end
    end

    assign level  = level_ff;
    assign change = change_ff;

endmodule

// ---- core/fog_top.sv ----
module fog_top #(
    parameter int PWM_TICKS   = fog_pkg::PWM_TICKS_DEF,
    parameter int BLINK_TICKS = fog_pkg::BLINK_TICKS_DEF
) (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // System mode and failure state
    input  wire fog_pkg::fog_mode_t sys_mode,
    input  wire logic               fail_flag,
    input  wire logic               restart_by_fail,
    // Indicator pin, two-way
    input  wire logic               ind_pin_in,
    output logic                    ind_pin_out,
    output logic                    ind_pin_oe,
    // Pulsed output and strap pin, two-way
    input  wire logic               pls_pin_in,
    output logic                    pls_pin_out,
    output logic                    pls_pin_oe,
    // Towards mode controller
    output logic                    wake_pulse,
    output logic                    strap_level
);
    import fog_pkg::*;

    localparam logic [9:0]  TICK_LAST  = 10'(TICK_CYC - 1);
    localparam logic [15:0] PWM_LAST   = 16'(PWM_TICKS - 1);
    localparam logic [15:0] BLINK_LAST = 16'(BLINK_TICKS - 1);

    // Bus state
    logic        wr_pend_ff;
    logic [7:0]  addr_ff;
    logic [31:0] hrdata_ff;
    logic        nxt_wr_pend;
    logic [7:0]  nxt_addr;
    logic [31:0] nxt_hrdata;
    logic        addr_ok;

    // Settings and status
    logic [1:0][2:0] cfg_ff;
    logic [1:0][2:0] nxt_cfg;
    logic [1:0]  duty_ff;
    logic [1:0]  nxt_duty;
    logic [1:0]  sw_ff;
    logic [1:0]  nxt_sw;
    logic [1:0]  wake_ff;
    logic [1:0]  nxt_wake;
    logic [1:0]  lvl_ff;
    logic [1:0]  nxt_lvl;
    logic        fo_hold_ff;
    logic        nxt_fo_hold;
    logic        wake_pulse_ff;
    logic        nxt_wake_pulse;
    logic        strap_ff;
    logic        wr_cfg;
    logic        wr_sw;
    logic        wr_wake;
    logic        in_normal;
    logic        sw_block;

    // Pattern generator
    logic [9:0]  tick_ff;
    logic [9:0]  nxt_tick;
    logic [15:0] pwm_ff;
    logic [15:0] nxt_pwm;
    logic [15:0] blink_ff;
    logic [15:0] nxt_blink;
    logic        phase_ff;
    logic        nxt_phase;
    logic        tick_en;
    logic        fo_act;
    logic [1:0]  fo_pat;

    // Pin state
    logic [1:0]  filt_lvl;
    logic [1:0]  filt_chg;
    logic [1:0]  pin_raw;
    logic [1:0]  wake_cap;
    logic [1:0]  wake_ev;
    logic [1:0]  out_ff;
    logic [1:0]  oe_ff;
    logic [1:0]  nxt_out;
    logic [1:0]  nxt_oe;

    assign pin_raw   = {pls_pin_in, ind_pin_in};
    assign in_normal = (sys_mode == MODE_NORMAL);

    // Input filters for wake and strap use
    for (genvar i = 0; i < 2; i++) begin : g_filt
        fog_pin_filt u_filt (
            .hclk    (hclk),
            .hresetn (hresetn),
            .pin_raw (pin_raw[i]),
            .level   (filt_lvl[i]),
            .change  (filt_chg[i])
        );
    end

    // Address phase; only whole words taken
    assign addr_ok = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);

    // Read data is sampled in the address phase, valid in the data phase
    always_comb begin
        nxt_wr_pend = addr_ok & hwrite;
        nxt_addr    = addr_ok ? haddr[7:0] : addr_ff;
        nxt_hrdata  = 32'h00000000;
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                ADDR_PIN_CFG: begin
                    nxt_hrdata[CFG_A_LSB +: CFG_W]   = cfg_ff[0];
                    nxt_hrdata[CFG_B_LSB +: CFG_W]   = cfg_ff[1];
                    nxt_hrdata[DUTY_LSB +: DUTY_W]   = duty_ff;
                end
                ADDR_SW_CTRL:   nxt_hrdata[1:0] = sw_ff;
                ADDR_WAKE_STAT: nxt_hrdata[1:0] = wake_ff;
                ADDR_LVL_STAT:  nxt_hrdata[1:0] = lvl_ff;
                default:        nxt_hrdata = 32'h00000000;
            endcase
        end
    end

    // Data phase writes; settings ignored outside Normal mode
    assign wr_cfg  = wr_pend_ff & (addr_ff == ADDR_PIN_CFG) & in_normal;
    assign wr_sw   = wr_pend_ff & (addr_ff == ADDR_SW_CTRL) & in_normal;
    assign wr_wake = wr_pend_ff & (addr_ff == ADDR_WAKE_STAT);

    // Settings hold through every other mode
    always_comb begin
        nxt_cfg  = cfg_ff;
        nxt_duty = duty_ff;
        nxt_sw   = sw_ff;
        if (wr_cfg) begin
            nxt_cfg[0] = hwdata[CFG_A_LSB +: CFG_W];
            nxt_cfg[1] = hwdata[CFG_B_LSB +: CFG_W];
            nxt_duty   = hwdata[DUTY_LSB +: DUTY_W];
        end
        if (wr_sw) begin
            nxt_sw = hwdata[1:0];
        end
    end

    // Wake capability: lost only in Fail-Safe, off pins never wake
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            wake_cap[i] = (cfg_ff[i] == FUNC_WAKE)
                        & (sys_mode != MODE_FAILSAFE);
        end
        wake_ev = wake_cap & filt_chg;
    end

    // Wake status is write-one-to-clear; a new event beats the clear
    always_comb begin
        nxt_wake = wake_ff;
        if (wr_wake) begin
            nxt_wake = wake_ff & ~hwdata[1:0];
        end
        nxt_wake       = nxt_wake | wake_ev;
        nxt_wake_pulse = |wake_ev;
    end

    // Level readback, frozen outside Normal and Stop
    always_comb begin
        nxt_lvl = lvl_ff;
        if (in_normal || sys_mode == MODE_STOP) begin
            nxt_lvl[0] = (cfg_ff[0] == FUNC_WAKE || cfg_ff[0] == FUNC_LOW ||
                          cfg_ff[0] == FUNC_HIGH) ? filt_lvl[0] : 1'b0;
            nxt_lvl[1] = filt_lvl[1];
        end
    end

    // Failure hold kept through Restart into Normal
    always_comb begin
        nxt_fo_hold = fo_hold_ff;
        if (sys_mode == MODE_FAILSAFE ||
            (sys_mode == MODE_RESTART && restart_by_fail)) begin
            nxt_fo_hold = 1'b1;
        end else if (in_normal && !fail_flag) begin
            nxt_fo_hold = 1'b0;
        end
    end

    assign fo_act = fo_hold_ff | fail_flag | (sys_mode == MODE_FAILSAFE);

    // Time base from the internal clock; patterns restart on activation
    assign tick_en = (tick_ff == TICK_LAST);

    always_comb begin
        nxt_tick  = tick_en ? 10'h000 : tick_ff + 10'h001;
        nxt_pwm   = pwm_ff;
        nxt_blink = blink_ff;
        nxt_phase = phase_ff;
        if (!fo_act) begin
            nxt_tick  = 10'h000;
            nxt_pwm   = 16'h0000;
            nxt_blink = 16'h0000;
            nxt_phase = 1'b1;
        end else if (tick_en) begin
            nxt_pwm = (pwm_ff == PWM_LAST) ? 16'h0000 : pwm_ff + 16'h0001;
            if (blink_ff == BLINK_LAST) begin
                nxt_blink = 16'h0000;
                nxt_phase = ~phase_ff;
            end else begin
                nxt_blink = blink_ff + 16'h0001;
            end
        end
    end

    // Indicator half on, pulsed output on for its share
    assign fo_pat[0] = phase_ff;
    assign fo_pat[1] = (pwm_ff < fog_duty_ticks(duty_ff, PWM_TICKS));

    // Switches off in Restart and Fail-Safe, then resume
    assign sw_block = (sys_mode == MODE_RESTART) | (sys_mode == MODE_FAILSAFE);

    // Pin drive per function; switches carry no diagnostics
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            nxt_out[i] = 1'b0;
            nxt_oe[i]  = 1'b0;
            case (cfg_ff[i])
                FUNC_FAIL: begin
                    nxt_oe[i] = fo_act & fo_pat[i];
                end
                FUNC_LOW: begin
                    nxt_oe[i] = sw_ff[i] & ~sw_block;
                end
                FUNC_HIGH: begin
                    nxt_oe[i]  = sw_ff[i] & ~sw_block;
                    nxt_out[i] = sw_ff[i] & ~sw_block;
                end
                default: begin
                    nxt_oe[i] = 1'b0;
                end
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
            hrdata_ff  <= 32'h00000000;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            addr_ff    <= nxt_addr;
            hrdata_ff  <= nxt_hrdata;
        end
    end

    // Setting and status registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff[0]     <= CFG_RST;
            cfg_ff[1]     <= CFG_RST;
            duty_ff       <= DUTY_RST;
            sw_ff         <= SW_RST;
            wake_ff       <= WAKE_RST;
            lvl_ff        <= LVL_RST;
            fo_hold_ff    <= 1'b0;
            wake_pulse_ff <= 1'b0;
            strap_ff      <= FILT_LVL_RST;
        end else begin
            cfg_ff        <= nxt_cfg;
            duty_ff       <= nxt_duty;
            sw_ff         <= nxt_sw;
            wake_ff       <= nxt_wake;
            lvl_ff        <= nxt_lvl;
            fo_hold_ff    <= nxt_fo_hold;
            wake_pulse_ff <= nxt_wake_pulse;
            strap_ff      <= filt_lvl[1];
        end
    end

    // Pattern and pin registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_ff  <= 10'h000;
            pwm_ff   <= 16'h0000;
            blink_ff <= 16'h0000;
            phase_ff <= 1'b1;
            out_ff   <= 2'h0;
            oe_ff    <= 2'h0;
        end else begin
            tick_ff  <= nxt_tick;
            pwm_ff   <= nxt_pwm;
            blink_ff <= nxt_blink;
            phase_ff <= nxt_phase;
            out_ff   <= nxt_out;
            oe_ff    <= nxt_oe;
        end
    end

    // Always ready, always OKAY: no access needs wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata      = hrdata_ff;
    assign ind_pin_out = out_ff[0];
    assign ind_pin_oe  = oe_ff[0];
    assign pls_pin_out = out_ff[1];
    assign pls_pin_oe  = oe_ff[1];
    assign wake_pulse  = wake_pulse_ff;
    assign strap_level = strap_ff;

endmodule

// ---- dv/fog_sva.sv ----
module fog_sva (
    // Clock and reset
    input wire logic               hclk,
    input wire logic               hresetn,
    // Bus
    input wire logic               hsel,
    input wire logic               hready,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [31:0]        hrdata,
    input wire logic               hreadyout,
    input wire logic               hresp,
    // Mode, pins and events
    input wire fog_pkg::fog_mode_t sys_mode,
    input wire logic               ind_pin_in,
    input wire logic               ind_pin_out,
    input wire logic               ind_pin_oe,
    input wire logic               pls_pin_in,
    input wire logic               pls_pin_out,
    input wire logic               pls_pin_oe,
    input wire logic               wake_pulse,
    input wire logic               strap_level
);
    timeunit 1ns;
    timeprecision 1ns;
    import fog_pkg::*;

    logic [15:0] ind_cnt_ff, pls_cnt_ff, nxt_ind_cnt, nxt_pls_cnt;
    logic        ind_last_ff, pls_last_ff;

    // Cycles each pin has held its level, saturating
    always_comb begin
        nxt_ind_cnt  = (ind_pin_in != ind_last_ff) ? 16'h0 : ind_cnt_ff + {15'h0, ~&ind_cnt_ff};
        nxt_pls_cnt  = (pls_pin_in != pls_last_ff) ? 16'h0 : pls_cnt_ff + {15'h0, ~&pls_cnt_ff};
    end

    // Counter registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ind_cnt_ff  <= 16'h0;
            pls_cnt_ff  <= 16'h0;
            ind_last_ff <= 1'b1;
            pls_last_ff <= 1'b1;
        end else begin
            ind_cnt_ff  <= nxt_ind_cnt;
            pls_cnt_ff  <= nxt_pls_cnt;
            ind_last_ff <= ind_pin_in;
            pls_last_ff <= pls_pin_in;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_OKAY: assert property (hresp == 1'b0)
        else $error("error response seen");
    AST_NOWAIT: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    AST_RDIDLE: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
        else $error("stray read data");
    AST_SW_OFF: assert property ((ind_pin_out || pls_pin_out) |->
        !($past(sys_mode) inside {MODE_RESTART, MODE_FAILSAFE}))
        else $error("high drive in restart or fail-safe");
    AST_OUT_OE: assert property ((ind_pin_out |-> ind_pin_oe) and (pls_pin_out |-> pls_pin_oe))
        else $error("level without drive enable");
    AST_WAKE_FS: assert property (wake_pulse |-> $past(sys_mode) != MODE_FAILSAFE)
        else $error("wake in fail-safe");
    AST_WAKE_ONE: assert property (wake_pulse |=> !wake_pulse)
        else $error("wake pulse too long");
    AST_WAKE_FILT: assert property (wake_pulse |-> (ind_cnt_ff > 16'h04FF || pls_cnt_ff > 16'h04FF))
        else $error("wake before filter time");
    AST_STRAP_FILT: assert property ($changed(strap_level) |-> pls_cnt_ff > 16'h04FF)
        else $error("strap moved before filter time");
    AST_STRAP_LVL: assert property (pls_cnt_ff == 16'h0514 |-> strap_level == pls_pin_in)
        else $error("strap not following settled pin");
endmodule

bind fog_top fog_sva fog_sva_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready), .htrans(htrans),
    .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sys_mode(sys_mode), .ind_pin_in(ind_pin_in), .ind_pin_out(ind_pin_out),
    .ind_pin_oe(ind_pin_oe), .pls_pin_in(pls_pin_in), .pls_pin_out(pls_pin_out),
    .pls_pin_oe(pls_pin_oe), .wake_pulse(wake_pulse), .strap_level(strap_level)
);

// ---- dv/fog_pins.sv ----
module fog_pins (
    // Design drive
    input  wire logic ind_pin_out,
    input  wire logic ind_pin_oe,
    input  wire logic pls_pin_out,
    input  wire logic pls_pin_oe,
    // Wake switches to ground, closed when high
    input  wire logic ind_sw_close,
    input  wire logic pls_sw_close,
    // Resolved pin levels
    output logic      ind_pin_in,
    output logic      pls_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driver wins, else a closed switch pulls low, else pull-up high
    assign ind_pin_in = ind_pin_oe ? ind_pin_out : ~ind_sw_close;
    assign pls_pin_in = pls_pin_oe ? pls_pin_out : ~pls_sw_close;
endmodule

// ---- dv/fog_top_tb.sv ----
module fog_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fog_pkg::*;

    // Short patterns keep the run brief
    localparam int PWM_T   = 40;
    localparam int BLINK_T = 4;

    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    fog_mode_t   sys_mode;
    logic        fail_flag, restart_by_fail, ind_sw, pls_sw, wake_pulse, strap_level;
    logic        ind_pin_in, ind_pin_out, ind_pin_oe, pls_pin_in, pls_pin_out, pls_pin_oe;
    int          mismatches, checks_done, wakes = 0, n, w0;
    int          pm [4] = '{PERMILLE_20, PERMILLE_10, PERMILLE_5, PERMILLE_2P5};

    // Bus clock
    always #(CLK_PERIOD_NS / 2) hclk = ~hclk;
    assign hready = hreadyout;

    // Count wake pulses
    always @(posedge hclk) if (wake_pulse === 1'b1) wakes <= wakes + 1;

    fog_top #(.PWM_TICKS(PWM_T), .BLINK_TICKS(BLINK_T)) fog_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sys_mode(sys_mode), .fail_flag(fail_flag),
        .restart_by_fail(restart_by_fail), .ind_pin_in(ind_pin_in), .ind_pin_out(ind_pin_out),
        .ind_pin_oe(ind_pin_oe), .pls_pin_in(pls_pin_in), .pls_pin_out(pls_pin_out),
        .pls_pin_oe(pls_pin_oe), .wake_pulse(wake_pulse), .strap_level(strap_level)
    );

    fog_pins fog_pins_inst (
        .ind_pin_out(ind_pin_out), .ind_pin_oe(ind_pin_oe), .pls_pin_out(pls_pin_out),
        .pls_pin_oe(pls_pin_oe), .ind_sw_close(ind_sw), .pls_sw_close(pls_sw),
        .ind_pin_in(ind_pin_in), .pls_pin_in(pls_pin_in)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One word, each phase held until hready is high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        check(nm, r, e);
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge hclk);
        #1;
    endtask

    task automatic setm(input fog_mode_t m, input logic ff, input logic rb);
        @(posedge hclk);
        sys_mode        <= m;
        fail_flag       <= ff;
        restart_by_fail <= rb;
    endtask

    task automatic sw(input logic i, input logic p);
        @(posedge hclk);
        ind_sw <= i;
        pls_sw <= p;
    endtask

    // Drive state as {ind oe, ind out, pls oe, pls out}
    task automatic chk_pins(input string nm, input logic [3:0] e);
        check(nm, {28'h0, ind_pin_oe, ind_pin_out, pls_pin_oe, pls_pin_out}, {28'h0, e});
    endtask

    // Cycles of the next run at level lv, bounded against a stuck pin
    task automatic run_len(input logic w, input logic lv, output int len);
        int g = 0;
        len = 0;
        while ((w ? pls_pin_oe : ind_pin_oe) !== lv && g < 30000) begin
            cyc(1);
            g++;
        end
        while ((w ? pls_pin_oe : ind_pin_oe) === lv && len < 30000) begin
            cyc(1);
            len++;
        end
    endtask

    // Hang guard
    initial begin
        repeat (80000) @(posedge hclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        sys_mode = MODE_NORMAL;
        fail_flag = 1'b0;
        restart_by_fail = 1'b0;
        ind_sw = 1'b0;
        pls_sw = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("pin_cfg", ADDR_PIN_CFG, 32'h0);
        rd_chk("sw_ctrl", ADDR_SW_CTRL, 32'h0);
        rd_chk("wake_stat", ADDR_WAKE_STAT, 32'h0);
        rd_chk("unmapped", 8'h10, 32'h0);
        check("strap_rst", strap_level, 32'h1);
        // Pulse high time per duty code, default first
        for (int d = 0; d < 4; d++) begin
            if (d > 0) wr(ADDR_PIN_CFG, 32'(d) << DUTY_LSB);
            setm(MODE_NORMAL, 1'b1, 1'b0);
            run_len(1'b1, 1'b1, n);
            check("pulse_hi", n, PWM_T * pm[d] / 1000 * TICK_CYC);
            if (d == 0) begin
                run_len(1'b1, 1'b0, n);
                check("pulse_lo", n, (PWM_T - PWM_T * pm[0] / 1000) * TICK_CYC);
            end
            setm(MODE_NORMAL, 1'b0, 1'b0);
            cyc(3);
        end
        setm(MODE_NORMAL, 1'b1, 1'b0);
        run_len(1'b0, 1'b1, n);
        check("blink_on", n, BLINK_T * TICK_CYC);
        run_len(1'b0, 1'b0, n);
        check("blink_off", n, BLINK_T * TICK_CYC);
        setm(MODE_STOP, 1'b0, 1'b0);
        wr(ADDR_PIN_CFG, 32'h11);
        rd_chk("cfg_locked", ADDR_PIN_CFG, 32'h300);
        // Low-side on indicator pin, high-side on pulsed pin
        setm(MODE_NORMAL, 1'b0, 1'b0);
        wr(ADDR_PIN_CFG, 32'h343);
        wr(ADDR_SW_CTRL, 32'h3);
        cyc(1400);
        chk_pins("sw_on", 4'b1011);
        rd_chk("lvl_sw", ADDR_LVL_STAT, 32'h2);
        rd_chk("no_diag", ADDR_WAKE_STAT, 32'h0);
        setm(MODE_STOP, 1'b0, 1'b0);
        cyc(3);
        chk_pins("sw_stop", 4'b1011);
        setm(MODE_RESTART, 1'b0, 1'b0);
        cyc(3);
        chk_pins("sw_restart", 4'b0000);
        setm(MODE_NORMAL, 1'b0, 1'b0);
        cyc(3);
        chk_pins("sw_back", 4'b1011);
        rd_chk("cfg_kept", ADDR_PIN_CFG, 32'h343);
        // Wake on indicator pin, pulsed pin off; release edges cleared first
        wr(ADDR_SW_CTRL, 32'h0);
        wr(ADDR_PIN_CFG, 32'h312);
        cyc(1400);
        wr(ADDR_WAKE_STAT, 32'h3);
        w0 = wakes;
        sw(1'b1, 1'b0);
        cyc(1400);
        check("wake_pulse", wakes - w0, 32'h1);
        rd_chk("wake_set", ADDR_WAKE_STAT, 32'h1);
        rd_chk("lvl_wake", ADDR_LVL_STAT, 32'h2);
        wr(ADDR_WAKE_STAT, 32'h1);
        rd_chk("wake_w1c", ADDR_WAKE_STAT, 32'h0);
        sw(1'b1, 1'b1);
        cyc(1200);
        check("strap_early", strap_level, 32'h1);
        cyc(200);
        check("strap_late", strap_level, 32'h0);
        rd_chk("lvl_strap", ADDR_LVL_STAT, 32'h0);
        rd_chk("off_nowake", ADDR_WAKE_STAT, 32'h0);
        setm(MODE_FAILSAFE, 1'b0, 1'b0);
        sw(1'b0, 1'b1);
        cyc(1400);
        rd_chk("fs_nowake", ADDR_WAKE_STAT, 32'h0);
        setm(MODE_RESTART, 1'b0, 1'b0);
        sw(1'b1, 1'b1);
        cyc(1400);
        rd_chk("rs_wake", ADDR_WAKE_STAT, 32'h1);
        setm(MODE_NORMAL, 1'b0, 1'b0);
        rd_chk("cfg_wake_kept", ADDR_PIN_CFG, 32'h312);
        // Fail output activation across restart causes
        sw(1'b0, 1'b0);
        wr(ADDR_PIN_CFG, 32'h0);
        setm(MODE_RESTART, 1'b0, 1'b0);
        cyc(3);
        chk_pins("rs_plain", 4'b0000);
        setm(MODE_RESTART, 1'b0, 1'b1);
        cyc(3);
        chk_pins("rs_fail", 4'b1010);
        setm(MODE_NORMAL, 1'b1, 1'b0);
        cyc(3);
        chk_pins("fail_kept", 4'b1010);
        rd_chk("cfg_fail_kept", ADDR_PIN_CFG, 32'h0);
        setm(MODE_NORMAL, 1'b0, 1'b0);
        cyc(3);
        chk_pins("fail_clear", 4'b0000);
        setm(MODE_FAILSAFE, 1'b0, 1'b0);
        cyc(3);
        chk_pins("fs_fail", 4'b1010);
        report_and_stop();
    end
endmodule
